// file: core/efg_top.sv
// Summary of operation
// - flag sub-multiframe start entering generator
// - flag alignment word start entering generator
// - flag signaling multiframe start
// - flag CRC multiframe start
// - flag basic frame start
// - flags clear only on written one
// - rising request inverts four CRC bits
// - rising request inverts one CRC alignment pattern
// - rising request inverts one signaling alignment
// - rising request inverts one NFAS bit
// - rising request inverts whole seven-bit FAS
// - rising request inverts one FAS bit
// - request bits self-clear after inversion
// - request ignored unless its format generated
// - enabled flags drive the interrupt output
`timescale 1ns/100ps
`include "efg_params.svh"
module efg_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  aclk,          // transmit clock
  input  wire logic                  aresetn,       // sync reset, low
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,  // write address
  input  wire logic                  s_axi_awvalid, // write address valid
  output logic                       s_axi_awready, // write address ready
  input  wire logic [31:0]           s_axi_wdata,   // write data
  input  wire logic [3:0]            s_axi_wstrb,   // write strobes
  input  wire logic                  s_axi_wvalid,  // write data valid
  output logic                       s_axi_wready,  // write data ready
  output logic [1:0]                 s_axi_bresp,   // write response
  output logic                       s_axi_bvalid,  // write response valid
  input  wire logic                  s_axi_bready,  // write response ready
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,  // read address
  input  wire logic                  s_axi_arvalid, // read address valid
  output logic                       s_axi_arready, // read address ready
  output logic [31:0]                s_axi_rdata,   // read data
  output logic [1:0]                 s_axi_rresp,   // read response
  output logic                       s_axi_rvalid,  // read data valid
  input  wire logic                  s_axi_rready,  // read data ready
  // backplane bit stream
  input  wire logic                  bp_valid,      // backplane bit valid
  input  wire logic                  bp_data,       // backplane bit
  output logic                       bp_ready,      // generator takes bit
  // framed stream toward line
  output logic                       line_valid,    // framed bit valid
  output logic                       line_data,     // framed bit
  input  wire logic                  line_ready,    // line takes bit
  // status
  output efg_pkg::efg_mf_mode_t      mf_mode,       // current format
  output logic                       irq            // shared interrupt
);
  import efg_pkg::*;

  initial begin
    if (ADDR_W < 12) $error("efg_top: ADDR_W must be at least 12");
  end

  // register state
  logic [`EFG_FLAG_W-1:0] flags;
  logic [`EFG_FLAG_W-1:0] irq_en;
  logic [`EFG_INJ_W-1:0]  inj_ctl;
  logic [`EFG_INJ_W-1:0]  inj_prev;
  logic                   cas_en;

  // bus write capture
  logic [9:0]             aw_idx;
  logic                   aw_got;
  logic [31:0]            w_data;
  logic                   w_lane0;
  logic                   w_got;

  // frame position counters
  logic [2:0]             bit_cnt;
  logic [4:0]             ts_cnt;
  logic [3:0]             frm_cnt;

  // crc state
  logic [3:0]             crc_acc;
  logic [3:0]             crc_tx;

  // injection state
  logic [`EFG_INJ_W-1:0]  inj_pend;
  logic [`EFG_INJ_W-1:0]  inj_act;

  // write decode
  wire wr_go        = aw_got & w_got & ~s_axi_bvalid;
  wire wsel_irq_en  = (aw_idx == `EFG_IDX_IRQ_EN);
  wire wsel_flags   = (aw_idx == `EFG_IDX_FLAGS);
  wire wsel_inj     = (aw_idx == `EFG_IDX_ERR_INJ);
  wire wsel_fmt     = (aw_idx == `EFG_IDX_FMT_CTRL);
  wire wsel_any     = wsel_irq_en | wsel_flags | wsel_inj | wsel_fmt;
  wire wr_lane      = wr_go & w_lane0;
  wire wr_irq_en    = wr_lane & wsel_irq_en;
  wire wr_flags     = wr_lane & wsel_flags;
  wire wr_inj       = wr_lane & wsel_inj;
  wire wr_fmt       = wr_lane & wsel_fmt;
  wire [1:0] wr_resp = wsel_any ? `EFG_RESP_OKAY : `EFG_RESP_SLVERR;

  // read decode
  wire [9:0] ar_idx     = s_axi_araddr[11:2];
  wire       rsel_irq   = (ar_idx == `EFG_IDX_IRQ_EN);
  wire       rsel_flags = (ar_idx == `EFG_IDX_FLAGS);
  wire       rsel_inj   = (ar_idx == `EFG_IDX_ERR_INJ);
  wire       rsel_fmt   = (ar_idx == `EFG_IDX_FMT_CTRL);
  wire       rsel_any   = rsel_irq | rsel_flags | rsel_inj | rsel_fmt;
  wire [31:0] rd_fmt    = {29'h0000000, cas_en, mf_mode};
  wire [31:0] rd_mux    = rsel_irq   ? {27'h0000000, irq_en}  :
                          rsel_flags ? {27'h0000000, flags}   :
                          rsel_inj   ? {26'h0000000, inj_ctl} :
                          rsel_fmt   ? rd_fmt                 : 32'h00000000;

  // format requested by a write
  wire [1:0] wr_mode_f = w_data[`EFG_FMT_MODE_LSB+:2];
  wire efg_mf_mode_t next_mode = (wr_mode_f == 2'h1) ? EFG_MF_CRC     :
                                 (wr_mode_f == 2'h2) ? EFG_MF_MOD_CRC :
                                                       EFG_MF_BASIC;

  // frame position decode
  wire take      = bp_valid & bp_ready;
  wire even_frm  = ~frm_cnt[0];
  wire in_ts0    = (ts_cnt == 5'h00);
  wire in_ts16   = (ts_cnt == `EFG_TS_SIG);
  wire first_bit = (bit_cnt == 3'h0);
  wire crc_on    = (mf_mode == EFG_MF_CRC) | (mf_mode == EFG_MF_MOD_CRC);
  wire mfas_on   = (mf_mode == EFG_MF_CRC);
  wire mf_head   = (frm_cnt == 4'h0);
  wire mfas_frm  = (frm_cnt < `EFG_MFAS_FRAMES);
  wire frm_start = take & in_ts0 & first_bit;
  wire smf_start = frm_start & (frm_cnt[2:0] == 3'h0);
  wire mf_start  = frm_start & mf_head;

  // field positions within the frame
  wire pos_si    = in_ts0 & even_frm & first_bit;
  wire pos_fas   = in_ts0 & even_frm & ~first_bit;
  wire pos_fas1  = pos_fas & (bit_cnt == 3'h1);
  wire pos_odd1  = in_ts0 & ~even_frm & first_bit;
  wire pos_nfas  = in_ts0 & ~even_frm & (bit_cnt == 3'h1);
  wire pos_cas   = cas_en & in_ts16 & mf_head & (bit_cnt < 3'h4);
  wire pos_crcp  = pos_odd1 & mfas_on & mfas_frm;
  wire pos_crc   = pos_si & crc_on;

  // generated overhead bits
  wire [3:0] crc_cur  = (frm_cnt[2:1] == 2'h0) ? crc_acc : crc_tx;
  wire [2:0] fas_ix   = 3'h7 - bit_cnt;
  wire [1:0] crc_ix   = 2'h3 - frm_cnt[2:1];
  wire [2:0] mfas_ix  = 3'h5 - frm_cnt[3:1];
  wire       fas_bit  = 1'(`EFG_FAS_PAT >> fas_ix);
  wire       crc_bit  = crc_cur[crc_ix];
  wire       mfas_bit = mfas_frm ? 1'(`EFG_MFAS_PAT >> mfas_ix) : 1'b1;
  wire [1:0] cas_ix   = bit_cnt[1:0];
  wire       cas_bit  = 1'(`EFG_CAS_PAT >> cas_ix);
  wire       base_bit = pos_si   ? (crc_on ? crc_bit : 1'b1)   :
                        pos_fas  ? fas_bit                     :
                        pos_odd1 ? (mfas_on ? mfas_bit : 1'b1) :
                        pos_nfas ? 1'b1                        :
                        pos_cas  ? cas_bit                     : bp_data;

  // single error inversion onto the transmitted bit
  wire inv_bit = (inj_act[`EFG_INJ_FAS1]   & pos_fas1) |
                 (inj_act[`EFG_INJ_FASALL] & pos_fas)  |
                 (inj_act[`EFG_INJ_NFAS]   & pos_nfas) |
                 (inj_act[`EFG_INJ_CAS]    & pos_cas)  |
                 (inj_act[`EFG_INJ_CRCP]   & pos_crcp) |
                 (inj_act[`EFG_INJ_CRC]    & pos_crc);
  wire out_bit = base_bit ^ inv_bit;
  wire crc_in  = pos_crc ? 1'b0 : out_bit;

  // boundary events as each first bit enters the generator
  wire [`EFG_FLAG_W-1:0] ev_set;
  assign ev_set[`EFG_FLG_BASIC]  = frm_start;
  assign ev_set[`EFG_FLG_ALIGN]  = take & pos_fas1;
  assign ev_set[`EFG_FLG_SUBMF]  = smf_start & crc_on;
  assign ev_set[`EFG_FLG_CRC_MF] = mf_start & crc_on;
  assign ev_set[`EFG_FLG_SIG_MF] = mf_start & cas_en;

  // set wins over a written one in the same cycle
  wire [`EFG_FLAG_W-1:0] flag_clr   = wr_flags ? w_data[`EFG_FLAG_W-1:0] : '0;
  wire [`EFG_FLAG_W-1:0] next_flags = (flags & ~flag_clr) | ev_set;

  // per-request start points and format gates
  wire [`EFG_INJ_W-1:0] inj_start;
  wire [`EFG_INJ_W-1:0] inj_fmt_ok;
  assign inj_start[`EFG_INJ_FAS1]    = frm_start & even_frm;
  assign inj_start[`EFG_INJ_FASALL]  = frm_start & even_frm;
  assign inj_start[`EFG_INJ_NFAS]    = frm_start & ~even_frm;
  assign inj_start[`EFG_INJ_CAS]     = mf_start;
  assign inj_start[`EFG_INJ_CRCP]    = mf_start;
  assign inj_start[`EFG_INJ_CRC]     = smf_start;
  assign inj_fmt_ok[`EFG_INJ_FAS1]   = 1'b1;
  assign inj_fmt_ok[`EFG_INJ_FASALL] = 1'b1;
  assign inj_fmt_ok[`EFG_INJ_NFAS]   = 1'b1;
  assign inj_fmt_ok[`EFG_INJ_CAS]    = cas_en;
  assign inj_fmt_ok[`EFG_INJ_CRCP]   = mfas_on;
  assign inj_fmt_ok[`EFG_INJ_CRC]    = crc_on;

  logic [`EFG_INJ_W-1:0] inj_rise;
  logic [`EFG_INJ_W-1:0] inj_done;
  logic [`EFG_INJ_W-1:0] next_pend;
  logic [`EFG_INJ_W-1:0] next_act;

  // request edge tracking, one lane per injection type
  genvar gi;
  generate
    for (gi = 0; gi < `EFG_INJ_W; gi = gi + 1) begin : g_inj
      wire ok = inj_fmt_ok[gi];
      assign inj_rise[gi]  = inj_ctl[gi] & ~inj_prev[gi] & ok;
      assign inj_done[gi]  = (inj_start[gi] & inj_act[gi]) |
                             (inj_ctl[gi] & ~ok);
      assign next_pend[gi] = ok & ~inj_start[gi] & (inj_pend[gi] | inj_rise[gi]);
      assign next_act[gi]  = ok & (inj_start[gi] ? (inj_pend[gi] | inj_rise[gi])
                                                 : inj_act[gi]);
    end
  endgenerate

  // software value, then self-clear once a lane finishes
  wire [`EFG_INJ_W-1:0] inj_wr_val = wr_inj ? w_data[`EFG_INJ_W-1:0] : inj_ctl;
  wire [`EFG_INJ_W-1:0] next_inj   = inj_wr_val & ~inj_done;

  // crc-4 step, msb first
  function automatic logic [3:0] crc_step(input logic [3:0] acc, input logic b);
    logic fb;
    fb = acc[3] ^ b;
    crc_step = {acc[2:0], 1'b0} ^ (fb ? `EFG_CRC_POLY : 4'h0);
  endfunction

  // two-entry buffer toward the line
  efg_buf #(
    .WIDTH     (1)
  ) u_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (bp_valid),
    .in_data   (out_bit),
    .in_ready  (bp_ready),
    .out_valid (line_valid),
    .out_data  (line_data),
    .out_ready (line_ready)
  );

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EFG_RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_idx        <= 10'h000;
      w_data        <= 32'h00000000;
      w_lane0       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx        <= s_axi_awaddr[11:2];
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_lane0      <= s_axi_wstrb[0];
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_resp;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `EFG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rsel_any ? `EFG_RESP_OKAY : `EFG_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // control and status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags    <= `EFG_RST_FLAGS;
      irq_en   <= `EFG_RST_IRQ_EN;
      inj_ctl  <= `EFG_RST_INJ;
      inj_prev <= `EFG_RST_INJ;
      mf_mode  <= EFG_MF_BASIC;
      cas_en   <= 1'b0;
    end else begin
      flags    <= next_flags;
      inj_ctl  <= next_inj;
      inj_prev <= inj_ctl;
      if (wr_irq_en) irq_en <= w_data[`EFG_FLAG_W-1:0];
      if (wr_fmt) begin
        mf_mode <= next_mode;
        cas_en  <= w_data[`EFG_FMT_CAS];
      end
    end
  end

  // interrupt from enabled flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_en);
    end
  end

  // injection lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inj_pend <= '0;
      inj_act  <= '0;
    end else begin
      inj_pend <= next_pend;
      inj_act  <= next_act;
    end
  end

  // bit, timeslot and frame counters advance per accepted bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt <= 3'h0;
      ts_cnt  <= 5'h00;
      frm_cnt <= 4'h0;
    end else if (take) begin
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        ts_cnt <= ts_cnt + 5'h01;
        if (ts_cnt == 5'h1F) frm_cnt <= frm_cnt + 4'h1;
      end
    end
  end

  // crc over each sub-multiframe, latched at its end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_acc <= 4'h0;
      crc_tx  <= 4'h0;
    end else if (take) begin
      if (smf_start) begin
        crc_tx  <= crc_acc;
        crc_acc <= crc_step(4'h0, crc_in);
      end else begin
        crc_acc <= crc_step(crc_acc, crc_in);
      end
    end
  end
endmodule

// file: core/efg_params.svh
`ifndef EFG_PARAMS_SVH
`define EFG_PARAMS_SVH

// register indices, byte address is four times the index
`define EFG_IDX_IRQ_EN      10'h06D
`define EFG_IDX_FLAGS       10'h06E
`define EFG_IDX_ERR_INJ     10'h06F
`define EFG_IDX_FMT_CTRL    10'h0F0

// event flag positions
`define EFG_FLG_BASIC       0
`define EFG_FLG_CRC_MF      1
`define EFG_FLG_SIG_MF      2
`define EFG_FLG_ALIGN       3
`define EFG_FLG_SUBMF       4
`define EFG_FLAG_W          5

// error injection positions
`define EFG_INJ_FAS1        0
`define EFG_INJ_FASALL      1
`define EFG_INJ_NFAS        2
`define EFG_INJ_CAS         3
`define EFG_INJ_CRCP        4
`define EFG_INJ_CRC         5
`define EFG_INJ_W           6

// format control fields
`define EFG_FMT_MODE_LSB    0
`define EFG_FMT_CAS         2

// reset values
`define EFG_RST_FLAGS       5'h00
`define EFG_RST_INJ         6'h00
`define EFG_RST_IRQ_EN      5'h00

// frame structure patterns
`define EFG_FAS_PAT         7'h1B
`define EFG_MFAS_PAT        6'h0B
`define EFG_CAS_PAT         4'h0
`define EFG_CRC_POLY        4'h3
`define EFG_TS_SIG          5'h10
`define EFG_MFAS_FRAMES     4'hC

// bus responses
`define EFG_RESP_OKAY       2'h0
`define EFG_RESP_SLVERR     2'h2

`endif

// file: core/efg_pkg.sv
package efg_pkg;
  // multiframe format selected for generation
  typedef enum logic [1:0] {
    EFG_MF_BASIC,
    EFG_MF_CRC,
    EFG_MF_MOD_CRC
  } efg_mf_mode_t;
endpackage

// file: core/efg_buf.sv
`timescale 1ns/100ps
module efg_buf #(
  parameter int WIDTH = 1
) (
  input  wire logic             aclk,      // clock
  input  wire logic             aresetn,   // sync reset, low
  input  wire logic             in_valid,  // write side valid
  input  wire logic [WIDTH-1:0] in_data,   // write side data
  output logic                  in_ready,  // room for a word
  output logic                  out_valid, // head word present
  output logic      [WIDTH-1:0] out_data,  // head word
  input  wire logic             out_ready  // reader takes head
);
  logic [WIDTH-1:0] slot1;
  logic             full1;
  logic [WIDTH-1:0] next_head;
  logic [WIDTH-1:0] next_slot1;
  logic             next_valid;
  logic             next_full1;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  initial begin
    if (WIDTH < 1) $error("efg_buf: WIDTH must be at least 1");
  end

  // two-slot shift: pop moves slot1 forward, push fills first free
  always_comb begin
    next_head  = out_data;
    next_slot1 = slot1;
    next_valid = out_valid;
    next_full1 = full1;
    if (pop) begin
      next_head  = slot1;
      next_valid = full1;
      next_full1 = 1'b0;
    end
    if (push) begin
      if (!next_valid) begin
        next_head  = in_data;
        next_valid = 1'b1;
      end else begin
        next_slot1 = in_data;
        next_full1 = 1'b1;
      end
    end
  end

  // storage and registered ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data  <= '0;
      slot1     <= '0;
      out_valid <= 1'b0;
      full1     <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      out_data  <= next_head;
      slot1     <= next_slot1;
      out_valid <= next_valid;
      full1     <= next_full1;
      in_ready  <= ~next_full1;
    end
  end
endmodule

// file: dv/efg_top_assertions.sv
`timescale 1ns/100ps
module efg_top_chk
  import efg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic         aclk,          // clock
  input wire logic         aresetn,       // reset, low
  input wire logic         s_axi_awvalid, // aw valid
  input wire logic         s_axi_awready, // aw ready
  input wire logic         s_axi_wvalid,  // w valid
  input wire logic         s_axi_wready,  // w ready
  input wire logic [1:0]   s_axi_bresp,   // b code
  input wire logic         s_axi_bvalid,  // b valid
  input wire logic         s_axi_bready,  // b ready
  input wire logic         s_axi_arvalid, // ar valid
  input wire logic         s_axi_arready, // ar ready
  input wire logic [31:0]  s_axi_rdata,   // r data
  input wire logic         s_axi_rvalid,  // r valid
  input wire logic         s_axi_rready,  // r ready
  input wire logic         bp_valid,      // source bit valid
  input wire logic         bp_ready,      // source bit taken
  input wire logic         line_valid,    // line bit valid
  input wire logic         line_data,     // line bit
  input wire logic         line_ready,    // line takes
  input wire efg_mf_mode_t mf_mode,       // format
  input wire logic         irq            // interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] bit_pos; // bit within frame on the wire
  // count framed bits that the line takes
  always_ff @(posedge aclk) begin
    if (!aresetn) bit_pos <= 8'h00;
    else if (line_valid && line_ready) bit_pos <= bit_pos + 8'h01;
  end
  aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready high after accept");
  b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("bvalid late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("rvalid late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  line_hold_a: assert property (line_valid && !line_ready |=> line_valid
    && $stable(line_data)) else $error("line bit dropped");
  stall_full_a: assert property (!bp_ready |-> line_valid)
    else $error("source stalled with empty buffer");
  stall_free_a: assert property (!bp_ready && line_valid && line_ready |-> ##[1:2] bp_ready)
    else $error("source stall outlasts pop");
  basic_bit_a: assert property (line_valid && line_ready && bit_pos == 8'h00
    && mf_mode == EFG_MF_BASIC |-> line_data) else $error("frame bit one low");
  irq_cause_a: assert property ($rose(irq) |-> $past(bp_valid && bp_ready, 2)
    || $past(s_axi_bvalid, 1)) else $error("irq rose without cause");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (!bp_ready);
  cover property ($rose(irq));
endmodule

bind efg_top efg_top_chk #(.ADDR_W(ADDR_W)) chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .bp_valid(bp_valid), .bp_ready(bp_ready), .line_valid(line_valid),
  .line_data(line_data), .line_ready(line_ready), .mf_mode(mf_mode), .irq(irq));

// file: dv/efg_partner.sv
`timescale 1ns/100ps
module efg_partner (
  input  wire logic aclk,             // clock
  input  wire logic aresetn,          // reset, low
  input  wire logic run,              // source offers bits
  input  wire logic stall,            // line refuses
  input  wire logic slow,             // line takes every other cycle
  input  wire logic bp_ready,         // generator takes bit
  input  wire logic line_valid,       // framed bit valid
  input  wire logic line_data,        // framed bit
  output logic      bp_valid = 1'b0,  // bit offered
  output logic      bp_data = 1'b0,   // bit value
  output logic      line_ready = 1'b0,// line takes bit
  output int        sent = 0,         // bits taken
  output int        rcvd = 0,         // bits received
  output int        fas_ok = 0,       // intact words
  output int        fas_all = 0,      // fully inverted words
  output int        fas_one = 0,      // one bit wrong
  output int        nfas_err = 0      // odd frame bit two low
);
  logic [6:0] sr = 7'h00;  // word bits so far
  logic [7:0] pos = 8'h00; // bit within frame
  logic       odd = 1'b0;  // odd frame
  wire  [6:0] word = {sr[5:0], line_data};
  wire        take = line_valid && line_ready;
  // source holds its bit until taken, idle data toggles
  always @(posedge aclk) begin
    if (!bp_valid || bp_ready) begin
      bp_valid <= run && aresetn;
      bp_data <= ~bp_data;
    end
    sent <= sent + int'(bp_valid && bp_ready);
    line_ready <= !stall && !(slow && line_ready);
  end
  // line side sorts the alignment words it sees
  always @(posedge aclk) begin
    if (take) begin
      rcvd <= rcvd + 1;
      pos <= pos + 8'h01;
      sr <= word;
      if (pos == 8'hFF) odd <= !odd;
      if (!odd && pos == 8'h07) begin
        fas_ok <= fas_ok + int'(word == 7'h1B);
        fas_all <= fas_all + int'(word == 7'h64);
        fas_one <= fas_one + int'($countones(word ^ 7'h1B) == 1);
      end
      if (odd && pos == 8'h01) nfas_err <= nfas_err + int'(!line_data);
    end
  end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/100ps
`include "efg_params.svh"
module tb_top;
  import efg_pkg::*;
  logic         aclk = 1'b0, aresetn = 1'b0, run = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [11:0]  awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]  wdata = 32'h0, rdata, rd;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic         rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
  logic         bp_valid, bp_data, bp_ready, line_valid, line_data, line_ready;
  logic [1:0]   bresp, rresp, resp;
  logic [23:0]  e0;
  efg_mf_mode_t mf_mode;
  int           sent, rcvd, fas_ok, fas_all, fas_one, nfas_err;
  int           error_cnt = 0, num_checks = 0;
  int           inj[3] = '{`EFG_INJ_FAS1, `EFG_INJ_FASALL, `EFG_INJ_NFAS};
  logic [23:0]  delta[3] = '{24'h000100, 24'h010000, 24'h000001};
  wire  [23:0]  errs = {fas_all[7:0], fas_one[7:0], nfas_err[7:0]};
  always #5 aclk = ~aclk;
  efg_top #(.ADDR_W(12)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bp_valid(bp_valid), .bp_data(bp_data), .bp_ready(bp_ready),
    .line_valid(line_valid), .line_data(line_data), .line_ready(line_ready),
    .mf_mode(mf_mode), .irq(irq));
  efg_partner far (.aclk(aclk), .aresetn(aresetn), .run(run), .stall(stall), .slow(slow),
    .bp_ready(bp_ready), .line_valid(line_valid), .line_data(line_data),
    .bp_valid(bp_valid), .bp_data(bp_data), .line_ready(line_ready), .sent(sent),
    .rcvd(rcvd), .fas_ok(fas_ok), .fas_all(fas_all), .fas_one(fas_one),
    .nfas_err(nfas_err));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one aligned word write, address and data offered together
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [9:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // let the source send n bits, then drain the line
  task automatic run_bits(input int n);
    int n0;
    n0 = sent;
    run <= 1'b1;
    while (sent < n0 + n) @(posedge aclk);
    run <= 1'b0;
    do @(posedge aclk); while (rcvd != sent || bp_valid);
  endtask
  task results;
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    results();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(`EFG_IDX_FLAGS);
    chk("flags reset", 0, rd);
    rdr(`EFG_IDX_ERR_INJ);
    chk("inject reset", 0, rd);
    rdr(10'h3FF);
    chk("unmapped", `EFG_RESP_SLVERR, resp);
    run_bits(300);
    rdr(`EFG_IDX_FLAGS);
    chk("basic flags", 32'h09, rd);
    wr(`EFG_IDX_FLAGS, 8'h00);
    chk("write resp", `EFG_RESP_OKAY, resp);
    rdr(`EFG_IDX_FLAGS);
    chk("zero write", 32'h09, rd);
    wr(`EFG_IDX_FLAGS, 8'h01);
    rdr(`EFG_IDX_FLAGS);
    chk("one clear", 32'h08, rd);
    wr(`EFG_IDX_FLAGS, 8'h08);
    wr(`EFG_IDX_IRQ_EN, 8'h01);
    run_bits(256);
    repeat (2) @(posedge aclk);
    chk("irq on", 1, irq);
    wr(`EFG_IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge aclk);
    chk("irq masked", 0, irq);
    rdr(`EFG_IDX_FLAGS);
    chk("flag sets masked", 32'h09, rd);
    // a refusing line fills the buffer, then a slow line drains it
    stall <= 1'b1;
    run <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("bp_ready full", 0, bp_ready);
    stall <= 1'b0;
    slow <= 1'b1;
    run_bits(700);
    slow <= 1'b0;
    chk("bits lost", sent, rcvd);
    chk("fas intact", 1, 32'(fas_ok != 0));
    chk("no inversion", 0, errs);
    for (int i = 0; i < 3; i++) begin
      e0 = errs;
      wr(`EFG_IDX_ERR_INJ, 8'h01 << inj[i]);
      run_bits(1100);
      rdr(`EFG_IDX_ERR_INJ);
      chk("inject clear", 0, rd);
      chk("inversions", e0 + delta[i], errs);
    end
    wr(`EFG_IDX_ERR_INJ, 8'h38);
    rdr(`EFG_IDX_ERR_INJ);
    chk("ignored clear", 0, rd);
    wr(`EFG_IDX_FMT_CTRL, 8'h01);
    chk("mode", EFG_MF_CRC, mf_mode);
    wr(`EFG_IDX_FLAGS, 8'h1F);
    e0 = errs;
    wr(`EFG_IDX_ERR_INJ, 8'h01 << `EFG_INJ_NFAS);
    run_bits(4200);
    rdr(`EFG_IDX_ERR_INJ);
    chk("crc nfas clear", 0, rd);
    chk("crc nfas inject", e0 + 24'h000001, errs);
    rdr(`EFG_IDX_FLAGS);
    chk("crc flags", 32'h1B, rd);
    wr(`EFG_IDX_FMT_CTRL, 8'h05);
    wr(`EFG_IDX_FLAGS, 8'h1F);
    for (int i = 3; i < 6; i++) begin
      wr(`EFG_IDX_ERR_INJ, 8'h01 << i);
      run_bits(8400);
      rdr(`EFG_IDX_ERR_INJ);
      chk("crc inject clear", 0, rd);
    end
    rdr(`EFG_IDX_FLAGS);
    chk("cas flags", 32'h1F, rd);
    results();
  end
endmodule
